// file: src/spz_serial_port.sv
// Serial port zero: synchronous and asynchronous modes behind an AXI4-Lite register slave.
//
// Contract
// R1: Two mode bits pick one of four modes.
// R2: Upper control bit is mode or frame error.
// R3: Frame error set on bad stop, software clears.
// R4: 11-bit multiprocessor mode drops frames with ninth bit 0.
// R5: 10-bit multiprocessor mode drops frames without valid stop.
// R6: Synchronous clock is oscillator over 12 or 4.
// R7: Reception only while receive enable is set.
// R8: 11-bit modes send the transmit ninth bit.
// R9: Receive ninth bit holds ninth bit or stop.
// R10: Transmit done at eighth bit or stop start.
// R11: Receive done at eighth bit or mid-stop.
// R12: Buffer reads receive register, writes transmit register.
// R13: Baud doubler doubles rate in modes 1-3.
// R14: Masked address compare; zero mask accepts all.
// R15: Transmit on port 3.1, receive on port 3.0.
// R16: Buffer write starts frame after current frame.
// R17: Remote node matches format, rate and clock.
`timescale 1ns/1ps
module spz_serial_port (
  input wire logic aclk, // System clock, 40 MHz.
  input wire logic aresetn, // Synchronous active-low reset.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rxd_in, // Serial input pin, port 3.0 level.
  output logic rxd_out, // Port 3.0 drive value in synchronous mode.
  output logic rxd_oe, // Port 3.0 output enable.
  output logic txd_out, // Serial output or shift clock, port 3.1.
  output logic irq // Level interrupt.
);
  logic [7:0] ctrl_q, pcon_q, slave_match_address_q, slave_match_mask_q, tbuf_q, rbuf_q;
  logic [15:0] reload_q;
  logic [2:0] ist_q, imask_q;
  logic fe_q, tx_pend_q;
  logic aw_q, w_q;
  logic [9:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic rx_s;
  logic tick_sync, tick_os;
  logic [15:0] sync_per, os_per;
  spz_pkg::spz_mode_t mode;
  logic fe_sel, mp_sel, dbl;

  assign fe_sel = pcon_q[spz_pkg::PC_FRAME_ERROR_SELECT];
  assign dbl = pcon_q[spz_pkg::PC_BAUD_DOUBLER];
  assign mp_sel = ctrl_q[spz_pkg::SC_MP_SELECT];
  // The stored mode-high bit keeps steering while the position shows the error flag.
  assign mode = spz_pkg::spz_mode_t'(ctrl_q[7:6]); // R1 R2

  spz_sync2 u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(rxd_in),
    .dout(rx_s)
  );

  // Shift clock half period: a bit time is two ticks.
  assign sync_per = mp_sel ? 16'(spz_pkg::SYNC_DIV_FAST / 2 - 1)
                           : 16'(spz_pkg::SYNC_DIV_SLOW / 2 - 1); // R6
  spz_tick #(.W(16)) u_sync_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .period(sync_per),
    .tick(tick_sync)
  );

  // Oversample tick: fixed divider in mode 2, else the reload.
  always_comb
  begin
    if (mode == spz_pkg::SPZ_MODE_FIXED11)
      os_per = dbl ? 16'(spz_pkg::FIXED_DIV_FAST / spz_pkg::OVERSAMPLE - 1)
                   : 16'(spz_pkg::FIXED_DIV_SLOW / spz_pkg::OVERSAMPLE - 1); // R13
    else
      os_per = dbl ? {1'b0, reload_q[15:1]} : reload_q; // R13
  end
  spz_tick #(.W(16)) u_os_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .period(os_per),
    .tick(tick_os)
  );

  // Transmitter.
  typedef enum logic [1:0] {SPZ_TX_IDLE, SPZ_TX_SHIFT, SPZ_TX_STOP} spz_tx_state_t;
  spz_tx_state_t tx_st_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bit_q, tx_os_q, tx_len;
  logic tx_phase_q, tx_done_ev;
  assign tx_len = (mode == spz_pkg::SPZ_MODE_ASYNC10) ? 4'd9 : 4'd10;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_q <= SPZ_TX_IDLE;
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_os_q <= '0;
      tx_phase_q <= 1'b0;
      txd_out <= 1'b1;
      tx_done_ev <= 1'b0;
    end
    else
    begin
      tx_done_ev <= 1'b0;
      unique case (tx_st_q)
        SPZ_TX_IDLE:
        begin
          txd_out <= 1'b1;
          if (tx_pend_q) // R16
          begin
            tx_st_q <= SPZ_TX_SHIFT;
            tx_bit_q <= '0;
            tx_os_q <= '0;
            tx_phase_q <= 1'b0;
            if (mode == spz_pkg::SPZ_MODE_SYNC)
              tx_sh_q <= {2'b11, tbuf_q};
            else if (mode == spz_pkg::SPZ_MODE_ASYNC10)
              tx_sh_q <= {1'b1, tbuf_q, 1'b0};
            else
              tx_sh_q <= {ctrl_q[spz_pkg::SC_TX_NINTH], tbuf_q, 1'b0}; // R8
          end
        end
        SPZ_TX_SHIFT:
        begin
          if (mode == spz_pkg::SPZ_MODE_SYNC)
          begin
            // Data on port 3.0, clock low then high on port 3.1.
            if (tick_sync)
            begin
              tx_phase_q <= ~tx_phase_q;
              txd_out <= tx_phase_q;
              if (tx_phase_q)
              begin
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_bit_q <= tx_bit_q + 1'b1;
                if (tx_bit_q == 4'd7)
                begin
                  tx_st_q <= SPZ_TX_IDLE;
                  tx_done_ev <= 1'b1; // R10
                end
              end
            end
          end
          else
          begin
            txd_out <= tx_sh_q[0]; // R15
            if (tick_os)
            begin
              tx_os_q <= tx_os_q + 1'b1;
              if (tx_os_q == 4'd15)
              begin
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_bit_q <= tx_bit_q + 1'b1;
                if (tx_bit_q == tx_len - 4'd1)
                begin
                  tx_st_q <= SPZ_TX_STOP;
                  tx_done_ev <= 1'b1; // R10
                end
              end
            end
          end
        end
        SPZ_TX_STOP:
        begin
          txd_out <= 1'b1;
          if (tick_os)
          begin
            tx_os_q <= tx_os_q + 1'b1;
            if (tx_os_q == 4'd15)
              tx_st_q <= SPZ_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receiver.
  typedef enum logic [1:0] {SPZ_RX_IDLE, SPZ_RX_START, SPZ_RX_DATA, SPZ_RX_SYNC} spz_rx_state_t;
  spz_rx_state_t rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bit_q, rx_os_q, rx_nbits;
  logic rx_phase_q, rx_prev_q, rx_done_ev, fe_ev;
  logic [7:0] rx_byte;
  logic rx_ninth, addr_hit;
  assign rx_nbits = (mode == spz_pkg::SPZ_MODE_ASYNC10) ? 4'd8 : 4'd9;
  assign rx_byte = (mode == spz_pkg::SPZ_MODE_ASYNC10) ? rx_sh_q[8:1] : rx_sh_q[7:0];
  assign rx_ninth = rx_sh_q[8];
  // Masked compare; broadcast falls out when the mask is zero.
  assign addr_hit = ((rx_byte ^ slave_match_address_q) & slave_match_mask_q) == 8'h00; // R14

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_q <= SPZ_RX_IDLE;
      rx_sh_q <= '0;
      rx_bit_q <= '0;
      rx_os_q <= '0;
      rx_phase_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      rx_done_ev <= 1'b0;
      fe_ev <= 1'b0;
      rbuf_q <= spz_pkg::RST_BYTE;
    end
    else
    begin
      rx_done_ev <= 1'b0;
      fe_ev <= 1'b0;
      rx_prev_q <= rx_s;
      rxd_oe <= 1'b0;
      unique case (rx_st_q)
        SPZ_RX_IDLE:
        begin
          rx_os_q <= '0;
          rx_bit_q <= '0;
          rx_phase_q <= 1'b0;
          if (ctrl_q[spz_pkg::SC_RX_ENABLE]) // R7
          begin
            if (mode == spz_pkg::SPZ_MODE_SYNC)
            begin
              if (!ctrl_q[spz_pkg::SC_RX_DONE])
                rx_st_q <= SPZ_RX_SYNC;
            end
            else if (rx_prev_q && !rx_s)
              rx_st_q <= SPZ_RX_START;
          end
        end
        SPZ_RX_START:
        begin
          if (tick_os)
          begin
            rx_os_q <= rx_os_q + 1'b1;
            if (rx_os_q == 4'd7)
            begin
              rx_os_q <= '0;
              rx_st_q <= rx_s ? SPZ_RX_IDLE : SPZ_RX_DATA; // False start rejected.
            end
          end
        end
        SPZ_RX_DATA:
        begin
          if (tick_os)
          begin
            rx_os_q <= rx_os_q + 1'b1;
            if (rx_os_q == 4'd15)
            begin
              rx_bit_q <= rx_bit_q + 1'b1;
              if (rx_bit_q == rx_nbits)
              begin
                // Mid-stop sample: flag and filter in the same cycle.
                rx_st_q <= SPZ_RX_IDLE;
                fe_ev <= ~rx_s; // R3
                if (mode == spz_pkg::SPZ_MODE_ASYNC10)
                begin
                  if (!ctrl_q[spz_pkg::SC_RX_DONE] && (!mp_sel || rx_s)) // R5
                  begin
                    rbuf_q <= rx_byte;
                    rx_done_ev <= 1'b1; // R11
                  end
                end
                else if (!ctrl_q[spz_pkg::SC_RX_DONE] && (!mp_sel || (rx_ninth && addr_hit))) // R4
                begin
                  rbuf_q <= rx_byte;
                  rx_done_ev <= 1'b1; // R11
                end
              end
              else
                rx_sh_q <= {rx_s, rx_sh_q[8:1]};
            end
          end
        end
        SPZ_RX_SYNC:
        begin
          // Data in on port 3.0 on every second tick; port 3.1 stays high, so no shift clock is driven.
          if (tick_sync)
          begin
            rx_phase_q <= ~rx_phase_q;
            if (rx_phase_q)
            begin
              rx_sh_q <= {rx_s, rx_sh_q[8:1]};
              rx_bit_q <= rx_bit_q + 1'b1;
              if (rx_bit_q == 4'd7)
              begin
                rx_st_q <= SPZ_RX_IDLE;
                rbuf_q <= {rx_s, rx_sh_q[8:2]};
                rx_done_ev <= 1'b1; // R11
              end
            end
          end
        end
      endcase
      // Synchronous transmit drives data out on port 3.0.
      if (mode == spz_pkg::SPZ_MODE_SYNC && tx_st_q == SPZ_TX_SHIFT)
      begin
        rxd_oe <= 1'b1; // R15
        rxd_out <= tx_sh_q[0];
      end
    end
  end

  // Write channel capture: address and data accepted in either order.
  logic wr_go, bad_w;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  // Decoded from the held address, so the response matches the write it answers.
  assign bad_w = !(awa_q == spz_pkg::ADDR_SERIAL_CONTROL || awa_q == spz_pkg::ADDR_SERIAL_BUFFER
    || awa_q == spz_pkg::ADDR_POWER_CONTROL || awa_q == spz_pkg::ADDR_SLAVE_MATCH_ADDRESS
    || awa_q == spz_pkg::ADDR_SLAVE_MATCH_MASK || awa_q == spz_pkg::ADDR_BAUD_RELOAD
    || awa_q == spz_pkg::ADDR_IRQ_STATUS || awa_q == spz_pkg::ADDR_IRQ_MASK);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr[9:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bad_w ? 2'b10 : 2'b00;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; a hardware flag set beats a software clear.
  logic wr_ctrl, wr_buf;
  assign wr_ctrl = wr_go && ws_q[0] && awa_q == spz_pkg::ADDR_SERIAL_CONTROL;
  assign wr_buf = wr_go && ws_q[0] && awa_q == spz_pkg::ADDR_SERIAL_BUFFER;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= spz_pkg::RST_SERIAL_CONTROL;
      pcon_q <= spz_pkg::RST_POWER_CONTROL;
      slave_match_address_q <= spz_pkg::RST_BYTE;
      slave_match_mask_q <= spz_pkg::RST_BYTE;
      tbuf_q <= spz_pkg::RST_BYTE;
      reload_q <= spz_pkg::RST_BAUD_RELOAD;
      imask_q <= '0;
      fe_q <= 1'b0;
      tx_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // With error select on, bit 7 writes reach the error flag, not the mode.
        if (fe_sel)
        begin
          ctrl_q[6:0] <= wd_q[6:0];
          fe_q <= wd_q[7]; // R2
        end
        else
          ctrl_q <= wd_q[7:0]; // R1
      end
      if (wr_go && awa_q == spz_pkg::ADDR_POWER_CONTROL && ws_q[0])
        pcon_q <= wd_q[7:0];
      if (wr_go && awa_q == spz_pkg::ADDR_SLAVE_MATCH_ADDRESS && ws_q[0])
        slave_match_address_q <= wd_q[7:0];
      if (wr_go && awa_q == spz_pkg::ADDR_SLAVE_MATCH_MASK && ws_q[0])
        slave_match_mask_q <= wd_q[7:0];
      if (wr_go && awa_q == spz_pkg::ADDR_BAUD_RELOAD)
      begin
        if (ws_q[0])
          reload_q[7:0] <= wd_q[7:0];
        if (ws_q[1])
          reload_q[15:8] <= wd_q[15:8];
      end
      if (wr_go && awa_q == spz_pkg::ADDR_IRQ_MASK && ws_q[0])
        imask_q <= wd_q[2:0];
      if (wr_buf) // R12
        tbuf_q <= wd_q[7:0];
      if (wr_buf)
        tx_pend_q <= 1'b1; // R16
      else if (tx_st_q == SPZ_TX_IDLE && tx_pend_q)
        tx_pend_q <= 1'b0;
      if (tx_done_ev)
        ctrl_q[spz_pkg::SC_TX_DONE] <= 1'b1; // R10
      if (rx_done_ev)
      begin
        ctrl_q[spz_pkg::SC_RX_DONE] <= 1'b1; // R11
        if (mode != spz_pkg::SPZ_MODE_SYNC && !(mode == spz_pkg::SPZ_MODE_ASYNC10 && mp_sel))
          ctrl_q[spz_pkg::SC_RX_NINTH] <= (mode == spz_pkg::SPZ_MODE_ASYNC10) ? rx_s
                                                                             : rx_ninth; // R9
      end
      if (fe_ev && fe_sel)
        fe_q <= 1'b1; // R3
    end
  end

  // Sticky interrupt status, write one to clear, set beats clear.
  logic [2:0] iev;
  assign iev = {fe_ev && fe_sel, tx_done_ev, rx_done_ev};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ist_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_go && awa_q == spz_pkg::ADDR_IRQ_STATUS && ws_q[0])
        ist_q <= (ist_q & ~wd_q[2:0]) | iev;
      else
        ist_q <= ist_q | iev;
      irq <= |(ist_q & imask_q);
    end
  end

  // Read channel: answer one cycle after the address is taken.
  logic [31:0] rd_mux;
  logic [9:0] ra;
  logic rd_ok;
  assign ra = s_axi_araddr[9:0];
  always_comb
  begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (ra)
      spz_pkg::ADDR_SERIAL_CONTROL: rd_mux[7:0] = {fe_sel ? fe_q : ctrl_q[7], ctrl_q[6:0]}; // R2
      spz_pkg::ADDR_SERIAL_BUFFER: rd_mux[7:0] = rbuf_q; // R12
      spz_pkg::ADDR_POWER_CONTROL: rd_mux[7:0] = pcon_q;
      spz_pkg::ADDR_SLAVE_MATCH_ADDRESS: rd_mux[7:0] = slave_match_address_q;
      spz_pkg::ADDR_SLAVE_MATCH_MASK: rd_mux[7:0] = slave_match_mask_q;
      spz_pkg::ADDR_BAUD_RELOAD: rd_mux[15:0] = reload_q;
      spz_pkg::ADDR_IRQ_STATUS: rd_mux[2:0] = ist_q;
      spz_pkg::ADDR_IRQ_MASK: rd_mux[2:0] = imask_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : spz_serial_port

// file: src/spz_pkg.sv
// Package holding register map, field positions and timing constants of serial port zero.
package spz_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_SLAVE_MATCH_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_MATCH_MASK = 8'hB9;
  localparam logic [7:0] IDX_BAUD_RELOAD = 8'hF0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hF1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF2;
  localparam logic [9:0] ADDR_SERIAL_CONTROL = {IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_SERIAL_BUFFER = {IDX_SERIAL_BUFFER, 2'b00};
  localparam logic [9:0] ADDR_POWER_CONTROL = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_SLAVE_MATCH_ADDRESS = {IDX_SLAVE_MATCH_ADDRESS, 2'b00};
  localparam logic [9:0] ADDR_SLAVE_MATCH_MASK = {IDX_SLAVE_MATCH_MASK, 2'b00};
  localparam logic [9:0] ADDR_BAUD_RELOAD = {IDX_BAUD_RELOAD, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  // Serial control field positions.
  localparam int SC_MODE_HIGH = 7;
  localparam int SC_MODE_LOW = 6;
  localparam int SC_MP_SELECT = 5;
  localparam int SC_RX_ENABLE = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  // Power control field positions.
  localparam int PC_BAUD_DOUBLER = 7;
  localparam int PC_FRAME_ERROR_SELECT = 6;
  // Interrupt status bits.
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_FRAME_ERROR = 2;
  // Reset values.
  localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_BAUD_RELOAD = 16'h0000;
  // Fixed-rate dividers: synchronous mode bit clock and mode 2 bit time.
  localparam int SYNC_DIV_SLOW = 12;
  localparam int SYNC_DIV_FAST = 4;
  localparam int FIXED_DIV_SLOW = 64;
  localparam int FIXED_DIV_FAST = 32;
  // Sixteen samples per asynchronous bit time.
  localparam int OVERSAMPLE = 16;
  // Serial modes.
  typedef enum logic [1:0] {SPZ_MODE_SYNC, SPZ_MODE_ASYNC10, SPZ_MODE_FIXED11,
    SPZ_MODE_VAR11} spz_mode_t;
endpackage : spz_pkg

// file: src/spz_sync2.sv
// Two flip-flop synchroniser for a pin level.
`timescale 1ns/1ps
module spz_sync2 (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous active-low reset.
  input wire logic din, // Asynchronous level.
  output logic dout // Synchronised level.
);
  logic meta_q;

  // Idle high so a line at rest is not seen as a start bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : spz_sync2

// file: src/spz_tick.sv
// Programmable tick generator for serial bit timing.
`timescale 1ns/1ps
module spz_tick #(
  parameter int W = 16 // Counter width.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous active-low reset.
  input wire logic [W-1:0] period, // Cycles per tick minus one.
  output logic tick // One-cycle pulse.
);
  logic [W-1:0] cnt_q;

  // Counts down and reloads, so a period change takes effect after the current tick.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q == '0)
    begin
      cnt_q <= period;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : spz_tick

// file: tb/spz_serial_port_sva.sv
// Port checks for serial port zero.
`timescale 1ns/1ps
module spz_serial_port_sva (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic s_axi_awvalid, // Bus.
  input wire logic s_axi_awready, // Bus.
  input wire logic s_axi_wvalid, // Bus.
  input wire logic s_axi_wready, // Bus.
  input wire logic s_axi_bvalid, // Bus.
  input wire logic s_axi_bready, // Bus.
  input wire logic s_axi_arvalid, // Bus.
  input wire logic s_axi_arready, // Bus.
  input wire logic s_axi_rvalid, // Bus.
  input wire logic s_axi_rready, // Bus.
  input wire logic txd_out, // Serial out.
  input wire logic rxd_oe, // Pin enable.
  input wire logic irq // Interrupt.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Write answer follows the data beat.
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_soon;
    ##[1:6] s_axi_bvalid;
  endsequence
  property p_b_answer; s_w_taken |-> s_b_soon; endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_aw_taken; s_axi_awvalid && !s_axi_awready |-> ##[1:2] s_axi_awready; endproperty
  a_aw_taken: assert property (p_aw_taken) else $error("address stuck");
  property p_w_taken; s_axi_wvalid && !s_axi_wready |-> ##[1:2] s_axi_wready; endproperty
  a_w_taken: assert property (p_w_taken) else $error("data stuck");
  property p_ar_taken; $rose(s_axi_arvalid) |=> s_axi_arready; endproperty
  a_ar_taken: assert property (p_ar_taken) else $error("read stuck");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer stays");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer stays");
  // Out of reset the line idles high, pin released.
  property p_idle; $rose(aresetn) |-> txd_out && !rxd_oe && !irq; endproperty
  a_idle: assert property (p_idle) else $error("bad idle");
endmodule : spz_serial_port_sva
bind spz_serial_port spz_serial_port_sva u_chk (.*);

// file: tb/spz_remote_node.sv
// Remote serial node model.
`timescale 1ns/1ps
module spz_remote_node (
  input wire logic aclk, // Clock.
  input wire logic [7:0] bit_len, // Cycles per bit.
  input wire logic [3:0] nbits, // Bits after start.
  input wire logic send, // Send request.
  input wire logic [10:0] frame, // Start bit first.
  input wire logic txd_out, // Device output.
  output logic rxd_in, // Line to device.
  output logic [9:0] heard // Bits heard.
);
  initial rxd_in = 1'b1;
  initial heard = 10'h000;
  // Device format and rate, low bit first; idles high.
  always @(posedge aclk)
    if (send)
    begin
      for (int i = 0; i <= nbits; i++)
      begin
        rxd_in <= frame[i];
        repeat (bit_len) @(posedge aclk);
      end
      rxd_in <= 1'b1;
    end
  // Mid-bit sampling keeps edge skew harmless.
  always @(negedge txd_out)
  begin
    repeat (bit_len / 2) @(posedge aclk);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (bit_len) @(posedge aclk);
      heard[i] <= txd_out;
    end
  end
endmodule : spz_remote_node

// file: tb/testbench.sv
// Self-checking bench for serial port zero.
`timescale 1ns/1ps
module testbench;
  localparam logic [9:0] CTL = spz_pkg::ADDR_SERIAL_CONTROL;
  localparam logic [9:0] BUF = spz_pkg::ADDR_SERIAL_BUFFER;
  localparam logic [9:0] PWR = spz_pkg::ADDR_POWER_CONTROL;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, send = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, nb = 4'h9;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rxd_out, rxd_oe, txd_out, irq, line;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic [31:0] s_axi_rdata, rdat, x, seed = 32'h6;
  logic [7:0] bl = 8'h10;
  logic [10:0] frame = 11'h7FF;
  logic [9:0] heard;
  int failures = 0, checks = 0, cyc = 0, last = 0, per = 0;
  // Device drives the shared pin while enabled.
  wire logic rxd_in = rxd_oe ? rxd_out : line;
  spz_serial_port u_spz_serial_port (.*);
  spz_remote_node u_spz_remote_node (.aclk, .bit_len(bl), .nbits(nb), .send, .frame,
    .txd_out, .rxd_in(line), .heard);
  // Clock; shift clock period in cycles.
  initial
    forever #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc++;
  always @(posedge txd_out)
  begin
    per = cyc - last;
    last = cyc;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Bits heard after start; top bit clear in ten-bit mode.
  function automatic logic [9:0] hexp(input int m, input logic [7:0] d, input logic b);
    return (m == 1) ? {2'b01, d} : {1'b1, b, d};
  endfunction : hexp
  task automatic complete_run(input int extra);
    failures = failures + extra;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Each bus task opens on a fresh edge so no signal is driven twice in one step.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 60);
    s_axi_bready <= 1'b0;
    if (n >= 60) complete_run(1);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 60);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    if (n >= 60) complete_run(1);
  endtask : rd
  task automatic poll(input int b);
    int n = 0;
    do
    begin
      rd(CTL);
      n++;
    end
    while (rdat[b] !== 1'b1 && n < 300);
    if (n >= 300) complete_run(1);
  endtask : poll
  // Node sends one frame, then read receive done; mode 2 frames take 352 cycles.
  task automatic rxe(input logic [7:0] c, input logic [7:0] d, input logic b, input logic e);
    wr(CTL, c);
    @(posedge aclk);
    frame <= {1'b1, b, d, 1'b0};
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (400) @(posedge aclk);
    rd(CTL);
    chk(rdat[0], e);
  endtask : rxe
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTL);
    chk(rdat, 32'h0);
    rd(10'h004);
    chk(rrsp, 2'h2);
    // Each async mode: a frame in and out.
    for (int m = 1; m < 4; m++)
    begin
      x = rnd();
      bl <= (m == 2) ? 8'h20 : 8'h10;
      nb <= (m == 1) ? 4'h9 : 4'hA;
      wr(PWR, (m == 2) ? 8'h80 : 8'h00);
      rxe({m[1:0], 2'b01, x[8], 3'b000}, x[15:8], (m == 1) | x[16], 1'b1);
      chk(rdat[2], (m == 1) | x[16]);
      rd(BUF);
      chk(rdat, {24'h0, x[15:8]});
      wr(BUF, x[7:0]);
      poll(1);
      repeat (32) @(posedge aclk);
      chk(heard, hexp(m, x[7:0], x[8]));
    end
    wr(PWR, 8'h00);
    rxe(8'hC0, x[7:0], 1'b1, 1'b0);
    rxe(8'hF0, x[7:0], 1'b0, 1'b0);
    rxe(8'hF0, x[7:0], 1'b1, 1'b1);
    wr(spz_pkg::ADDR_SLAVE_MATCH_ADDRESS, x[7:0]);
    wr(spz_pkg::ADDR_SLAVE_MATCH_MASK, 8'hF0);
    rxe(8'hF0, {~x[7:4], x[3:0]}, 1'b1, 1'b0);
    rxe(8'hF0, {x[7:4], ~x[3:0]}, 1'b1, 1'b1);
    // Bad stop: frame dropped, error flag up; mode high cleared first.
    nb <= 4'h9;
    wr(CTL, 8'h40);
    wr(PWR, 8'h40);
    rxe(8'h70, x[7:0], 1'b0, 1'b0);
    chk(rdat[7], 1'b1);
    wr(spz_pkg::ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(spz_pkg::ADDR_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(CTL, 8'h70);
    rd(CTL);
    chk(rdat[7], 1'b0);
    // Sync mode: clock period per select bit.
    for (int s = 0; s < 2; s++)
    begin
      wr(CTL, s ? 8'h20 : 8'h00);
      wr(BUF, x[7:0]);
      poll(1);
      chk(per, s ? 32'h4 : 32'hC);
    end
    complete_run(0);
  end
endmodule : testbench
